/* eirp_pkg.sv */
// Shared constants, types and helpers for the external interrupt and reset pin block
package eirp_pkg;
  // Pin slots of the synchroniser vector
  localparam int NPIN = 8;
  localparam int P_RST = 0;
  localparam int P_NMI = 1;
  localparam int P_IRQ = 2;
  localparam int P_IC1 = 3;
  localparam int P_IC2 = 4;
  localparam int P_IC3 = 5;
  localparam int P_PAI = 6;
  localparam int P_STROBE_A_INPUT = 7;
  localparam logic [NPIN-1:0] PIN_IDLE = 8'hFF;
  // Peripheral sources in status and mask registers
  localparam int NSRC = 5;
  localparam int S_IC1 = 0;
  localparam int S_IC2 = 1;
  localparam int S_IC3 = 2;
  localparam int S_PAI = 3;
  localparam int S_STROBE_A_INPUT = 4;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_EDGE = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam int WB_LANE0 = 0;
  // Control register fields
  localparam int C_EDGE = 0;
  localparam int C_XM = 1;
  localparam int C_IM = 2;
  localparam int C_NMI = 3;
  localparam int C_IPEND = 4;
  // Edge register fields
  localparam int E_IC1 = 0;
  localparam int E_IC2 = 2;
  localparam int E_IC3 = 4;
  localparam int E_PAI = 6;
  localparam int E_STROBE_A_INPUT = 7;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_ANY = 2'h3;
  // Reset values
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [NSRC-1:0] MASK_RST = 5'h00;
  localparam logic [NSRC-1:0] STAT_RST = 5'h00;
  // Reset pin drive time on a detected failure
  localparam int RST_HOLD_NS = 160;
  localparam int CLK_NS = 10;
  localparam logic [4:0] RST_HOLD_CYC = 5'((RST_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // Bus slave states
  typedef enum logic {WB_IDLE = 1'b0, WB_ACK = 1'b1} eirp_wb_t;
  // Edge match for a two-bit select: bit0 rising, bit1 falling
  function automatic logic eirp_edge_hit(logic [1:0] cfg, logic r, logic f);
    return (cfg[0] & r) | (cfg[1] & f);
  endfunction
endpackage

/* eirp_pin_if.sv */
// Carrier for synchronised pin levels and edge pulses
`timescale 1ns/1ps
interface eirp_pin_if;
  import eirp_pkg::*;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  modport src(output lvl, output rise, output fall);
  modport dst(input lvl, input rise, input fall);
endinterface

/* eirp_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module eirp_pin_sync
  import eirp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NPIN-1:0] pins_i,
  eirp_pin_if.src sync
);
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [NPIN-1:0] s3_ff;
  logic [NPIN-1:0] lvl_ff;
  logic [NPIN-1:0] rise_ff;
  logic [NPIN-1:0] fall_ff;
  logic [NPIN-1:0] nxt_lvl;

  // Level follows only where stages two and three agree
  always_comb begin
    nxt_lvl = (s3_ff & ~(s2_ff ^ s3_ff)) | (lvl_ff & (s2_ff ^ s3_ff));
  end

  // Synchroniser chain, first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= PIN_IDLE;
      s2_ff <= PIN_IDLE;
      s3_ff <= PIN_IDLE;
    end else if (ce_i) begin
      s1_ff <= pins_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Filtered level and one-cycle edge pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_ff <= PIN_IDLE;
      rise_ff <= '0;
      fall_ff <= '0;
    end else if (ce_i) begin
      lvl_ff <= nxt_lvl;
      rise_ff <= nxt_lvl & ~lvl_ff;
      fall_ff <= ~nxt_lvl & lvl_ff;
    end
  end

  assign sync.lvl = lvl_ff;
  assign sync.rise = rise_ff;
  assign sync.fall = fall_ff;
endmodule

/* eirp_top.sv */
// External interrupt and reset pin logic with a Wishbone register slave
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
module eirp_top
  import eirp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_pin_n_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  input wire logic clk_mon_fail_i,
  input wire logic operating_check_watchdog_fail_i,
  input wire logic nonmaskable_int_n_i,
  input wire logic irq_n_i,
  input wire logic capture_input_1_i,
  input wire logic capture_input_2_i,
  input wire logic capture_input_3_i,
  input wire logic pulse_accum_input_i,
  input wire logic strobe_a_input_i,
  input wire logic mode_expanded_i,
  input wire logic addr_strobe_core_i,
  output logic addr_latch_strobe_o,
  output logic addr_latch_strobe_oe_o,
  input wire logic irq_ack_i,
  output logic nmi_req_o,
  output logic irq_req_o
);
  eirp_pin_if pin_bus();
  logic [NPIN-1:0] pins;
  logic int_rst;
  eirp_wb_t wb_state_ff;
  eirp_wb_t nxt_wb_state;
  logic wb_hit;
  logic wr_lane0;
  logic rd_stat;
  logic [31:0] nxt_rdata;
  logic edge_mode_ff;
  logic x_mask_ff;
  logic i_mask_ff;
  logic [7:0] edge_cfg_ff;
  logic [NSRC-1:0] mask_ff;
  logic [NSRC-1:0] status_ff;
  logic [NSRC-1:0] ev;
  logic [NSRC-1:0] clr;
  logic irq_edge_ff;
  logic irq_pin_req;
  logic [4:0] hold_cnt_ff;

  // Gather pins for the synchroniser
  assign pins = {strobe_a_input_i, pulse_accum_input_i, capture_input_3_i,
                 capture_input_2_i, capture_input_1_i, irq_n_i,
                 nonmaskable_int_n_i, reset_pin_n_i};

  eirp_pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pins_i(pins),
    .sync(pin_bus.src)
  );

  // Internal reset from the bus reset or a low reset pin
  assign int_rst = rst_i | ~pin_bus.lvl[P_RST];

  // Bus request decode
  assign wb_hit = wb_cyc_i & wb_stb_i & (wb_state_ff == WB_IDLE);
  assign wr_lane0 = wb_hit & wb_we_i & wb_sel_i[WB_LANE0];
  assign rd_stat = wb_hit & ~wb_we_i & (wb_adr_i == A_STAT);

  // Bus handshake state: one ack per request, then a gap
  always_comb begin
    case (wb_state_ff)
      WB_IDLE: nxt_wb_state = (wb_cyc_i & wb_stb_i) ? WB_ACK : WB_IDLE;
      WB_ACK: nxt_wb_state = WB_IDLE;
      default: nxt_wb_state = WB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      wb_state_ff <= WB_IDLE;
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_state_ff <= nxt_wb_state;
      wb_ack_o <= (nxt_wb_state == WB_ACK);
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = '0;
    case (wb_adr_i)
      A_CTRL: begin
        nxt_rdata[C_EDGE] = edge_mode_ff;
        nxt_rdata[C_XM] = x_mask_ff;
        nxt_rdata[C_IM] = i_mask_ff;
        nxt_rdata[C_NMI] = pin_bus.lvl[P_NMI];
        nxt_rdata[C_IPEND] = irq_edge_ff;
      end
      A_EDGE: nxt_rdata[7:0] = edge_cfg_ff;
      A_MASK: nxt_rdata[NSRC-1:0] = mask_ff;
      A_STAT: nxt_rdata[NSRC-1:0] = status_ff;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      wb_dat_o <= '0;
    end else if (ce_i && wb_hit) begin
      wb_dat_o <= wb_we_i ? '0 : nxt_rdata;
    end
  end

  // Trigger mode and condition-code mask bits
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      edge_mode_ff <= 1'b0;
      x_mask_ff <= 1'b1;
      i_mask_ff <= 1'b1;
    end else if (ce_i && wr_lane0 && wb_adr_i == A_CTRL) begin
      edge_mode_ff <= wb_dat_i[C_EDGE];
      x_mask_ff <= x_mask_ff & wb_dat_i[C_XM];
      i_mask_ff <= wb_dat_i[C_IM];
    end
  end

  // Edge selects and local enables
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      edge_cfg_ff <= EDGE_RST;
      mask_ff <= MASK_RST;
    end else if (ce_i && wr_lane0) begin
      if (wb_adr_i == A_EDGE) begin
        edge_cfg_ff <= wb_dat_i[7:0];
      end
      if (wb_adr_i == A_MASK) begin
        mask_ff <= wb_dat_i[NSRC-1:0];
      end
    end
  end

  // Peripheral pin edge events
  always_comb begin
    ev[S_IC1] = eirp_edge_hit(edge_cfg_ff[E_IC1 +: 2], pin_bus.rise[P_IC1],
                              pin_bus.fall[P_IC1]);
    ev[S_IC2] = eirp_edge_hit(edge_cfg_ff[E_IC2 +: 2], pin_bus.rise[P_IC2],
                              pin_bus.fall[P_IC2]);
    ev[S_IC3] = eirp_edge_hit(edge_cfg_ff[E_IC3 +: 2], pin_bus.rise[P_IC3],
                              pin_bus.fall[P_IC3]);
    ev[S_PAI] = eirp_edge_hit({~edge_cfg_ff[E_PAI], edge_cfg_ff[E_PAI]},
                              pin_bus.rise[P_PAI], pin_bus.fall[P_PAI]);
    ev[S_STROBE_A_INPUT] = ~mode_expanded_i &
                 eirp_edge_hit({~edge_cfg_ff[E_STROBE_A_INPUT], edge_cfg_ff[E_STROBE_A_INPUT]},
                               pin_bus.rise[P_STROBE_A_INPUT], pin_bus.fall[P_STROBE_A_INPUT]);
  end

  // Flag clears by status read or write-one
  assign clr = (rd_stat ? {NSRC{1'b1}} : '0) |
               ((wr_lane0 && wb_adr_i == A_STAT) ? wb_dat_i[NSRC-1:0] : '0);

  // Sticky flags, a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      status_ff <= STAT_RST;
    end else if (ce_i) begin
      status_ff <= (status_ff & ~clr) | ev;
    end
  end

  // Falling-edge latch of the maskable input, cleared on acknowledge
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      irq_edge_ff <= 1'b0;
    end else if (ce_i) begin
      if (edge_mode_ff && pin_bus.fall[P_IRQ]) begin
        irq_edge_ff <= 1'b1;
      end else if (irq_ack_i || !edge_mode_ff) begin
        irq_edge_ff <= 1'b0;
      end
    end
  end

  // Level mode follows the line, so held-low shared sources retrigger
  assign irq_pin_req = edge_mode_ff ? irq_edge_ff : ~pin_bus.lvl[P_IRQ];

  // Interrupt request outputs
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      nmi_req_o <= 1'b0;
      irq_req_o <= 1'b0;
    end else if (ce_i) begin
      nmi_req_o <= ~x_mask_ff & ~pin_bus.lvl[P_NMI];
      irq_req_o <= ~i_mask_ff & (irq_pin_req | (|(status_ff & mask_ff)));
    end
  end

  // Open-drain reset drive, stretched so the pin is seen low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt_ff <= '0;
      reset_pin_oe_o <= 1'b0;
      reset_pin_o <= 1'b0;
    end else if (ce_i) begin
      reset_pin_o <= 1'b0;
      if (clk_mon_fail_i || operating_check_watchdog_fail_i) begin
        hold_cnt_ff <= RST_HOLD_CYC;
        reset_pin_oe_o <= 1'b1;
      end else if (hold_cnt_ff != '0) begin
        hold_cnt_ff <= hold_cnt_ff - 5'h01;
        reset_pin_oe_o <= 1'b1;
      end else begin
        reset_pin_oe_o <= 1'b0;
      end
    end
  end

  // Shared strobe pin becomes address strobe output in expanded modes
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      addr_latch_strobe_o <= 1'b0;
      addr_latch_strobe_oe_o <= 1'b0;
    end else if (ce_i) begin
      addr_latch_strobe_o <= mode_expanded_i & addr_strobe_core_i;
      addr_latch_strobe_oe_o <= mode_expanded_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Checks on the behaviour above
  x_set_a: assert property (ce_i && int_rst |=> x_mask_ff)
    else $error("X mask not set by reset");
  lvl_mode_a: assert property (ce_i && int_rst |=> !edge_mode_ff)
    else $error("Reset left edge trigger mode");
  nmi_masked_a: assert property (ce_i && x_mask_ff |=> !nmi_req_o)
    else $error("Nonmaskable request while X set");
  nmi_level_a: assert property (ce_i && !int_rst && !x_mask_ff &&
                                !pin_bus.lvl[P_NMI] |=> nmi_req_o)
    else $error("Low nonmaskable level not requested");
  fail_drive_a: assert property (ce_i && clk_mon_fail_i |=> reset_pin_oe_o [*2])
    else $error("Failure did not drive reset pin");
  i_gate_a: assert property (ce_i && i_mask_ff |=> !irq_req_o)
    else $error("Maskable request while I set");
  irq_retake_a: assert property (ce_i && !int_rst && !i_mask_ff && !edge_mode_ff &&
                                 !pin_bus.lvl[P_IRQ] |=> irq_req_o)
    else $error("Held low line not retaken");
  edge_latch_a: assert property (ce_i && !int_rst && edge_mode_ff &&
                                 pin_bus.fall[P_IRQ] |=> irq_edge_ff)
    else $error("Falling edge not latched");
  flag_set_a: assert property (ce_i && !int_rst && ev != '0 |=>
                               (status_ff & $past(ev)) == $past(ev))
    else $error("Event lost from status");
  strobe_a_input_exp_a: assert property (ce_i && !int_rst && mode_expanded_i &&
                               !status_ff[S_STROBE_A_INPUT] |=> !status_ff[S_STROBE_A_INPUT])
    else $error("Strobe event in expanded mode");
  as_drive_a: assert property (ce_i && !int_rst && mode_expanded_i |=>
                               addr_latch_strobe_oe_o)
    else $error("Address strobe not driven");
  ic_both_a: assert property (edge_cfg_ff[E_IC1 +: 2] == EDG_ANY &&
                              (pin_bus.rise[P_IC1] || pin_bus.fall[P_IC1])
                              |-> ev[S_IC1])
    else $error("Capture edge missed in any-edge mode");
  wb_ack_a: assert property (ce_i && !int_rst && wb_hit |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not single cycle");

  // Watchdog failure drives the pin like the clock monitor
  wdog_drive_a: assert property (ce_i && operating_check_watchdog_fail_i |=>
                                 reset_pin_oe_o [*2])
    else $error("Watchdog failure did not drive reset pin");

  // Drive holds while the stretch counter runs
  hold_drive_a: assert property (ce_i && hold_cnt_ff != '0 |=> reset_pin_oe_o)
    else $error("Reset drive ended early");

  // Low reset pin resets masks, mode and requests, but not the reset drive stretch or synchroniser
  pin_rst_a: assert property (ce_i && !rst_i && !pin_bus.lvl[P_RST] |=>
                              x_mask_ff && !edge_mode_ff && !irq_req_o && !nmi_req_o)
    else $error("Low reset pin did not reset state");

  // Acknowledge without a new edge drops the latch
  edge_clr_a: assert property (ce_i && !int_rst && irq_ack_i &&
                               !pin_bus.fall[P_IRQ] |=> !irq_edge_ff)
    else $error("Acknowledge left edge latch set");

  // No unmasked flag, an idle line and no latched edge give no request
  mask_gate_a: assert property (ce_i && !int_rst && (status_ff & mask_ff) == '0 &&
                                pin_bus.lvl[P_IRQ] && !irq_edge_ff |=> !irq_req_o)
    else $error("Masked flag raised a request");

  // Status read with no new event empties the flags
  flag_clr_a: assert property (ce_i && !int_rst && rd_stat && ev == '0 |=>
                               status_ff == '0)
    else $error("Status read did not clear flags");

  // Accumulator pin set to rising edges
  pai_edge_a: assert property (ce_i && !int_rst && pin_bus.rise[P_PAI] &&
                               edge_cfg_ff[E_PAI] |=> status_ff[S_PAI])
    else $error("Accumulator rising edge missed");

  // Strobe pin set to falling edges in single-chip mode
  strobe_a_input_edge_a: assert property (ce_i && !int_rst && !mode_expanded_i &&
                                pin_bus.fall[P_STROBE_A_INPUT] && !edge_cfg_ff[E_STROBE_A_INPUT] |=>
                                status_ff[S_STROBE_A_INPUT])
    else $error("Strobe falling edge missed");

  // Address strobe pin stays released in single-chip mode
  as_quiet_a: assert property (ce_i && !int_rst && !mode_expanded_i |=>
                               !addr_latch_strobe_oe_o && !addr_latch_strobe_o)
    else $error("Address strobe driven in single-chip mode");

  // Low clock enable freezes flags and requests
  ce_hold_a: assert property (!ce_i && !int_rst |=> $stable(status_ff) &&
                              $stable(irq_req_o) && $stable(nmi_req_o))
    else $error("State moved while clock enable low");

  irq_cov_c: cover property (ce_i && !i_mask_ff && status_ff[S_IC1] && mask_ff[S_IC1]);
  nmi_cov_c: cover property (nmi_req_o);
  rst_cov_c: cover property (reset_pin_oe_o);
  edge_cov_c: cover property (irq_edge_ff && irq_ack_i);
  stat_cov_c: cover property (rd_stat && status_ff != '0);
endmodule

/* eirp_src_model.sv */
// External interrupt sources and reset supervisor beside the pin block
`timescale 1ns/1ps
module eirp_src_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sup_hold_i,
  input wire logic dev_oe_i,
  input wire logic dev_val_i,
  input wire logic [1:0] req_i,
  input wire logic [1:0] ack_i,
  input wire logic nmi_src_i,
  output logic reset_pin_n_o,
  output logic irq_n_o,
  output logic nmi_n_o
);
  logic [1:0] hold_ff;
  // Each source keeps pulling until its own acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff <= 2'h0;
    end else begin
      hold_ff <= (hold_ff | req_i) & ~ack_i;
    end
  end
  // Pulled-up shared lines, sources only ever pull low
  assign irq_n_o = ~|hold_ff;
  assign nmi_n_o = ~nmi_src_i;
  // Reset wire: supervisor or device open-drain pulls low
  assign reset_pin_n_o = ~(sup_hold_i | (dev_oe_i & ~dev_val_i));
endmodule

/* tb_external_interrupt_reset_pins.sv */
// Self-checking bench for the external interrupt and reset pin block
`timescale 1ns/1ps
module tb_external_interrupt_reset_pins;
  import eirp_pkg::*;
  localparam int W = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, rpin_n, rpin_o, rpin_oe, nmi_n, irq_n, nmi_req, irq_req, as_o, as_oe;
  logic cmf = 1'b0;
  logic wdf = 1'b0;
  logic nsrc = 1'b0;
  logic irq_ack = 1'b0;
  logic mexp = 1'b0;
  logic ce = 1'b1;
  logic as_core = 1'b0;
  logic pulse_accum_input = 1'b1;
  logic strobe_a_input = 1'b1;
  logic [2:0] cap = 3'h7;
  logic [1:0] req = 2'h0;
  logic [1:0] sack = 2'h0;
  int fail_count = 0;
  int comparisons = 0;

  // Core clock
  always #5 clk_i = ~clk_i;

  eirp_src_model i_src (.clk_i(clk_i), .rst_i(rst_i), .sup_hold_i(1'b0),
    .dev_oe_i(rpin_oe), .dev_val_i(rpin_o), .req_i(req), .ack_i(sack),
    .nmi_src_i(nsrc), .reset_pin_n_o(rpin_n), .irq_n_o(irq_n), .nmi_n_o(nmi_n));

  eirp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .reset_pin_n_i(rpin_n), .reset_pin_o(rpin_o),
    .reset_pin_oe_o(rpin_oe), .clk_mon_fail_i(cmf), .operating_check_watchdog_fail_i(wdf),
    .nonmaskable_int_n_i(nmi_n), .irq_n_i(irq_n), .capture_input_1_i(cap[0]),
    .capture_input_2_i(cap[1]), .capture_input_3_i(cap[2]), .pulse_accum_input_i(pulse_accum_input),
    .strobe_a_input_i(strobe_a_input), .mode_expanded_i(mexp), .addr_strobe_core_i(as_core),
    .addr_latch_strobe_o(as_o), .addr_latch_strobe_oe_o(as_oe), .irq_ack_i(irq_ack),
    .nmi_req_o(nmi_req), .irq_req_o(irq_req));

  // Counts and verdict, ends the run
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Compare seen against expected
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single Wishbone cycle, read data left in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail_count++;
      test_done();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // One-cycle source request, source ack and core ack, then settle
  task src(input logic [1:0] r, input logic [1:0] a, input logic ia);
    req <= r;
    sack <= a;
    irq_ack <= ia;
    @(posedge clk_i);
    req <= 2'h0;
    sack <= 2'h0;
    irq_ack <= 1'b0;
    step(W);
  endtask

  // Main sequence
  initial begin
    step(5);
    rst_i <= 1'b0;
    step(6);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(q & (i == 0 ? 32'h7 : 32'hFF), (i == 0) ? 32'h6 : 32'h0);
    end
    $display("test reset values done");
    nsrc <= 1'b1;
    step(W);
    chk(nmi_req, 1'b0);
    wb(1'b1, A_CTRL, 32'h04);
    step(W);
    chk(nmi_req, 1'b1);
    nsrc <= 1'b0;
    step(W);
    chk(nmi_req, 1'b0);
    ce <= 1'b0;
    nsrc <= 1'b1;
    step(W);
    chk(nmi_req, 1'b0);
    ce <= 1'b1;
    step(W);
    chk(nmi_req, 1'b1);
    nsrc <= 1'b0;
    step(W);
    chk(nmi_req, 1'b0);
    $display("test nonmaskable done");
    wb(1'b1, A_CTRL, 32'h00);
    src(2'h3, 2'h0, 1'b0);
    chk(irq_req, 1'b1);
    src(2'h0, 2'h1, 1'b1);
    chk(irq_req, 1'b1);
    wb(1'b1, A_CTRL, 32'h04);
    step(2);
    chk(irq_req, 1'b0);
    wb(1'b1, A_CTRL, 32'h00);
    step(2);
    chk(irq_req, 1'b1);
    src(2'h0, 2'h2, 1'b1);
    chk(irq_req, 1'b0);
    wb(1'b1, A_CTRL, 32'h01);
    src(2'h1, 2'h0, 1'b0);
    chk(irq_req, 1'b1);
    wb(1'b0, A_CTRL, 32'h0);
    chk(q & 32'h1F, 32'h19);
    src(2'h0, 2'h0, 1'b1);
    chk(irq_req, 1'b0);
    src(2'h0, 2'h1, 1'b0);
    rst_i <= 1'b1;
    step(4);
    rst_i <= 1'b0;
    step(6);
    wb(1'b0, A_CTRL, 32'h0);
    chk(q & 32'h7, 32'h6);
    $display("test maskable done");
    wb(1'b1, A_MASK, 32'h1F);
    for (int i = 0; i < 3; i++) begin
      for (int m = 1; m < 4; m++) begin
        wb(1'b1, A_EDGE, 32'(m << (2 * i)));
        wb(1'b0, A_STAT, 32'h0);
        cap[i] <= 1'b0;
        step(W);
        wb(1'b0, A_STAT, 32'h0);
        chk(q, m[1] ? 32'h1 << i : 32'h0);
        cap[i] <= 1'b1;
        step(W);
        wb(1'b0, A_STAT, 32'h0);
        chk(q, m[0] ? 32'h1 << i : 32'h0);
        wb(1'b0, A_STAT, 32'h0);
        chk(q, 32'h0);
      end
    end
    cap[2] <= 1'b0;
    step(W);
    chk(irq_req, 1'b0);
    wb(1'b1, A_CTRL, 32'h00);
    step(2);
    chk(irq_req, 1'b1);
    wb(1'b1, A_MASK, 32'h00);
    step(2);
    chk(irq_req, 1'b0);
    wb(1'b1, A_STAT, 32'h1F);
    wb(1'b0, A_STAT, 32'h0);
    chk(q, 32'h0);
    cap[2] <= 1'b1;
    step(W);
    $display("test capture done");
    wb(1'b1, A_EDGE, 32'h40);
    wb(1'b0, A_STAT, 32'h0);
    pulse_accum_input <= 1'b0;
    strobe_a_input <= 1'b0;
    step(W);
    wb(1'b0, A_STAT, 32'h0);
    chk(q, 32'h10);
    pulse_accum_input <= 1'b1;
    strobe_a_input <= 1'b1;
    step(W);
    wb(1'b0, A_STAT, 32'h0);
    chk(q, 32'h08);
    mexp <= 1'b1;
    as_core <= 1'b1;
    step(3);
    chk({as_oe, as_o}, 2'h3);
    strobe_a_input <= 1'b0;
    step(W);
    wb(1'b0, A_STAT, 32'h0);
    chk(q, 32'h0);
    mexp <= 1'b0;
    as_core <= 1'b0;
    strobe_a_input <= 1'b1;
    step(W);
    $display("test strobe done");
    for (int f = 0; f < 2; f++) begin
      wb(1'b1, A_CTRL, 32'h00);
      cmf <= (f == 0);
      wdf <= (f == 1);
      step(1);
      cmf <= 1'b0;
      wdf <= 1'b0;
      step(2);
      chk({rpin_oe, rpin_n}, 2'h2);
      step(RST_HOLD_CYC - 2);
      chk(rpin_oe, 1'b1);
      step(2);
      chk(rpin_oe, 1'b0);
      step(W);
      wb(1'b0, A_CTRL, 32'h0);
      chk(q & 32'h7, 32'h6);
    end
    $display("test failure drive done");
    test_done();
  end
endmodule
